// ### src/ompf_pkg.sv
package ompf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE_STATUS = 8'h00;
  localparam logic [7:0] OFS_SYSCTRL = 8'h04;
  localparam logic [7:0] OFS_SYSCTRL_TWO = 8'h08;
  localparam logic [7:0] OFS_BUS_CTRL_LOW = 8'h0c;
  localparam logic [7:0] OFS_AREA_WIDTH = 8'h10;
  localparam logic [7:0] OFS_PORT_DIR = 8'h14;
  localparam logic [7:0] OFS_PIN_ROLE = 8'h18;
  localparam logic [7:0] OFS_ADDR_PROBE = 8'h1c;
  localparam logic [7:0] OFS_DECODE = 8'h20;
  // Field positions and reset values
  localparam int MODE_STATUS_FIXED_BIT = 7;
  localparam int RAM_ENABLE_BIT = 0;
  localparam int FLASH_SEL_BIT = 3;
  localparam int EXT_AREA_BIT = 5;
  localparam logic [7:0] SYSCTRL_RESET = 8'h01;
  localparam logic [7:0] SYSCTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] SYSCTRL_TWO_MASK = 8'h08;
  localparam logic [7:0] BUS_CTRL_LOW_RESET = 8'h00;
  // Address map
  localparam logic [23:0] FLASH_REG_LO = 24'hfffc8;
  localparam logic [23:0] FLASH_REG_HI = 24'hfffcb;
  localparam logic [23:0] RSVD_A_LO = 24'h060000;
  localparam logic [23:0] RSVD_A_HI = 24'h07ffff;
  localparam logic [23:0] RSVD_B_LO = 24'hff7400;
  localparam logic [23:0] RSVD_B_HI = 24'hff7bff;
  localparam logic [23:0] ROM_LO = 24'h000000;
  localparam logic [23:0] ROM_HI = 24'h05ffff;
  localparam logic [23:0] EAE_AREA_LO = 24'h040000;
  localparam logic [23:0] RAM_LO = 24'hff7c00;
  localparam logic [23:0] RAM_HI = 24'hffefbf;
  // Decode targets
  localparam logic [2:0] DEC_EXTERNAL = 3'h0;
  localparam logic [2:0] DEC_ROM = 3'h1;
  localparam logic [2:0] DEC_RAM = 3'h2;
  localparam logic [2:0] DEC_FLASH_REG = 3'h3;
  localparam logic [2:0] DEC_RESERVED = 3'h4;
  localparam logic [2:0] DEC_NONE = 3'h5;
  // Pin roles
  localparam logic [1:0] ROLE_PORT = 2'h0;
  localparam logic [1:0] ROLE_ADDR = 2'h1;
  localparam logic [1:0] ROLE_DATA = 2'h2;
  localparam logic [1:0] ROLE_CTRL = 2'h3;
  typedef enum logic [1:0] {
    OMPF_AX_IDLE = 2'b00,
    OMPF_AX_RESP = 2'b01
  } ompf_axstate_t;
endpackage

// ### src/ompf_mode_decode.sv
`timescale 1ns/10ps
`default_nettype none
module ompf_mode_decode
  import ompf_pkg::*;
(
  input wire logic [3:0] modeNum,
  output logic expanded,
  output logic romEnable,
  output logic flashProg,
  output logic bootMode,
  output logic userMode,
  output logic addrFromReset,
  output logic initWide,
  output logic legalMode
);
  always_comb
  begin
    expanded = 1'b0;
    romEnable = 1'b1;
    flashProg = 1'b0;
    bootMode = 1'b0;
    userMode = 1'b0;
    addrFromReset = 1'b0;
    initWide = 1'b0;
    legalMode = 1'b1;
    unique case (modeNum)
      4'd4:
      begin
        expanded = 1'b1;
        romEnable = 1'b0;
        addrFromReset = 1'b1;
        initWide = 1'b1;
      end
      4'd5:
      begin
        expanded = 1'b1;
        romEnable = 1'b0;
        addrFromReset = 1'b1;
      end
      4'd6: expanded = 1'b1;
      4'd7: expanded = 1'b0;
      4'd10, 4'd14:
      begin
        expanded = 1'b1;
        flashProg = 1'b1;
        bootMode = (modeNum == 4'd10);
        userMode = (modeNum == 4'd14);
      end
      4'd11, 4'd15:
      begin
        flashProg = 1'b1;
        bootMode = (modeNum == 4'd11);
        userMode = (modeNum == 4'd15);
      end
      default: legalMode = 1'b0; // Unsupported codes act single-chip
    endcase
  end
endmodule
`default_nettype wire

// ### src/ompf_top.sv
// Operation
// - Flash select bit set maps flash registers at FFFC8 to FFFCB.
// - Low three flash-select register bits read zero, ignore writes.
// - Modes four, five: ROM off, B-C and low five A bits address, D data, F control.
// - Mode four starts 16-bit; 8-bit only when all areas 8-bit.
// - Modes five, six start 8-bit; any 16-bit area widens, E data.
// - Mode six: ROM on, A-C inputs until direction bit set.
// - Mode seven: ROM on, no external space, all ports general.
// - Modes ten, fourteen: expanded ROM-on plus flash programming.
// - Modes eleven, fifteen: single-chip plus flash programming.
// - Ten, eleven are boot modes; fourteen, fifteen user program.
// - Port roles follow mode with per-mode reset defaults.
// - Port F gives control/clock or port function by mode.
// - Decode 16-megabyte space in eight areas.
// - External-area bit routes region external in expanded modes, else on-chip ROM.
// - RAM enable cleared routes RAM range external in expanded modes, to none in single-chip modes.
// - Mode number is binary of write-enable and three mode pins.
// - Mode status bits latch pins on register read; reset releases.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ompf_top
  import ompf_pkg::*;
#(
  parameter int AREAS = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] modeSelectPins,
  input wire logic flashWriteEnablePin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] activeMode,
  output logic romEnabled,
  output logic flashProgAllowed,
  output logic flashBootMode,
  output logic flashUserMode,
  output logic busWide,
  output logic [7:0] portAAddrEn,
  output logic [7:0] portBAddrEn,
  output logic [7:0] portCAddrEn,
  output logic portDDataEn,
  output logic portEDataEn,
  output logic [7:0] portFCtrlEn,
  output logic flashRegsMapped
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
    end
    else
    begin
      pinMeta_reg <= {flashWriteEnablePin, modeSelectPins};
      pinSync_reg <= pinMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode capture after reset release
  logic [3:0] mode_reg;
  logic [1:0] settle_reg;
  logic modeValid_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      settle_reg <= 2'h0;
      modeValid_reg <= 1'b0;
      mode_reg <= 4'h7;
    end
    else if (!modeValid_reg)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == 2'h2)
      begin
        mode_reg <= pinSync_reg;
        modeValid_reg <= 1'b1;
      end
    end
  end

  // One-cycle strobe once the captured mode has been decoded
  logic modeFresh_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      modeFresh_reg <= 1'b0;
    else
      modeFresh_reg <= !modeValid_reg && (settle_reg == 2'h2);
  end

  logic expanded, romEn, flashProg, bootMode, userMode;
  logic addrFromReset, initWide, legalMode;
  ompf_mode_decode uDecode (
    .modeNum(mode_reg),
    .expanded(expanded),
    .romEnable(romEn),
    .flashProg(flashProg),
    .bootMode(bootMode),
    .userMode(userMode),
    .addrFromReset(addrFromReset),
    .initWide(initWide),
    .legalMode(legalMode)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] sysCtrl_reg;
  logic [7:0] sysCtrlTwo_reg;
  logic [7:0] busCtrlLow_reg;
  logic [AREAS-1:0] areaWide_reg;
  logic [23:0] portDir_reg;
  logic [23:0] probeAddr_reg;
  logic [7:0] awAddr_reg;
  logic awHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic wHeld_reg;
  ompf_axstate_t rdState_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic [1:0] bResp_reg;
  logic bValid_reg;
  logic doWrite;
  logic [1:0] rdDecode;

  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready = !wHeld_reg && !bValid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = (rdState_reg == OMPF_AX_IDLE);
  assign s_axi_rvalid = (rdState_reg == OMPF_AX_RESP);
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  function automatic logic known(input logic [7:0] a);
    known = (a == OFS_MODE_STATUS) || (a == OFS_SYSCTRL)
      || (a == OFS_SYSCTRL_TWO) || (a == OFS_BUS_CTRL_LOW)
      || (a == OFS_AREA_WIDTH) || (a == OFS_PORT_DIR)
      || (a == OFS_PIN_ROLE) || (a == OFS_ADDR_PROBE)
      || (a == OFS_DECODE);
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old,
    input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg <= known(awAddr_reg) ? 2'h0 : 2'h2;
      end
      else if (bValid_reg && s_axi_bready)
        bValid_reg <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sysCtrl_reg <= SYSCTRL_RESET;
      sysCtrlTwo_reg <= SYSCTRL_TWO_RESET;
      busCtrlLow_reg <= BUS_CTRL_LOW_RESET;
      areaWide_reg <= '0;
      portDir_reg <= 24'h000000;
      probeAddr_reg <= 24'h000000;
    end
    else if (!modeValid_reg || modeFresh_reg)
      areaWide_reg <= {AREAS{initWide}};
    else if (doWrite)
    begin
      unique case (awAddr_reg)
        OFS_SYSCTRL: sysCtrl_reg <= merge8(sysCtrl_reg, wData_reg,
          wStrb_reg) & 8'hbf;
        OFS_SYSCTRL_TWO: sysCtrlTwo_reg <= merge8(sysCtrlTwo_reg,
          wData_reg, wStrb_reg) & SYSCTRL_TWO_MASK;
        OFS_BUS_CTRL_LOW: busCtrlLow_reg <= merge8(busCtrlLow_reg,
          wData_reg, wStrb_reg);
        OFS_AREA_WIDTH: areaWide_reg <= AREAS'(merge8(8'(areaWide_reg),
          wData_reg, wStrb_reg));
        OFS_PORT_DIR:
        begin
          for (int i = 0; i < 3; i++)
            if (wStrb_reg[i])
              portDir_reg[i*8 +: 8] <= wData_reg[i*8 +: 8];
        end
        OFS_ADDR_PROBE:
        begin
          for (int i = 0; i < 3; i++)
            if (wStrb_reg[i])
              probeAddr_reg[i*8 +: 8] <= wData_reg[i*8 +: 8];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [2:0] decodeTarget;
  function automatic logic inRange(input logic [23:0] a,
    input logic [23:0] lo, input logic [23:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  always_comb
  begin
    decodeTarget = DEC_EXTERNAL;
    if (sysCtrlTwo_reg[FLASH_SEL_BIT]
      && inRange(probeAddr_reg, FLASH_REG_LO, FLASH_REG_HI))
      decodeTarget = DEC_FLASH_REG;
    else if (inRange(probeAddr_reg, RSVD_A_LO, RSVD_A_HI)
      || inRange(probeAddr_reg, RSVD_B_LO, RSVD_B_HI))
      decodeTarget = DEC_RESERVED;
    else if (inRange(probeAddr_reg, RAM_LO, RAM_HI))
      decodeTarget = sysCtrl_reg[RAM_ENABLE_BIT] ? DEC_RAM
        : (expanded ? DEC_EXTERNAL : DEC_NONE);
    else if (romEn && inRange(probeAddr_reg, ROM_LO, ROM_HI))
      decodeTarget = (expanded && busCtrlLow_reg[EXT_AREA_BIT]
        && probeAddr_reg >= EAE_AREA_LO) ? DEC_EXTERNAL : DEC_ROM;
    else if (!expanded)
      decodeTarget = DEC_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin roles and bus width
  logic [2:0] probeArea;
  assign probeArea = probeAddr_reg[23:21];
  assign busWide = expanded && (|areaWide_reg);
  assign romEnabled = romEn;
  assign flashProgAllowed = flashProg;
  assign flashBootMode = bootMode;
  assign flashUserMode = userMode;
  assign activeMode = mode_reg;
  assign flashRegsMapped = sysCtrlTwo_reg[FLASH_SEL_BIT];

  always_comb
  begin
    portAAddrEn = 8'h00;
    portBAddrEn = 8'h00;
    portCAddrEn = 8'h00;
    portDDataEn = 1'b0;
    portEDataEn = 1'b0;
    portFCtrlEn = 8'h00;
    if (modeValid_reg && expanded)
    begin
      if (addrFromReset)
      begin
        portAAddrEn = {portDir_reg[7:5], 5'h1f};
        portBAddrEn = 8'hff;
        portCAddrEn = 8'hff;
      end
      else
      begin
        portAAddrEn = portDir_reg[7:0];
        portBAddrEn = portDir_reg[15:8];
        portCAddrEn = portDir_reg[23:16];
      end
      portDDataEn = 1'b1;
      portEDataEn = busWide;
      portFCtrlEn = {1'b1, 1'b0, 2'b11,
        !sysCtrl_reg[2], 3'b111};
    end
    else if (modeValid_reg)
      portFCtrlEn = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb
  begin
    rdDecode = 2'h0;
    if (!known(s_axi_araddr))
      rdDecode = 2'h2;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdState_reg <= OMPF_AX_IDLE;
      rData_reg <= 32'h00000000;
      rResp_reg <= 2'h0;
    end
    else
    begin
      unique case (rdState_reg)
        OMPF_AX_IDLE:
        if (s_axi_arvalid)
        begin
          rdState_reg <= OMPF_AX_RESP;
          rResp_reg <= rdDecode;
          rData_reg <= 32'h00000000;
          unique case (s_axi_araddr)
            OFS_MODE_STATUS: rData_reg <= {24'h0, 1'b1, 4'h0,
              pinSync_reg[2:0]};
            OFS_SYSCTRL: rData_reg <= {24'h0, sysCtrl_reg};
            OFS_SYSCTRL_TWO: rData_reg <= {24'h0,
              sysCtrlTwo_reg & SYSCTRL_TWO_MASK};
            OFS_BUS_CTRL_LOW: rData_reg <= {24'h0, busCtrlLow_reg};
            OFS_AREA_WIDTH: rData_reg <= 32'(areaWide_reg);
            OFS_PORT_DIR: rData_reg <= {8'h0, portDir_reg};
            OFS_PIN_ROLE: rData_reg <= {8'h0, flashUserMode,
              flashBootMode, flashProgAllowed, legalMode, busWide,
              romEnabled, expanded, modeValid_reg, 8'h0, 4'h0,
              mode_reg};
            OFS_ADDR_PROBE: rData_reg <= {8'h0, probeAddr_reg};
            OFS_DECODE: rData_reg <= {24'h0, 2'h0, probeArea,
              decodeTarget};
            default: rData_reg <= 32'h00000000;
          endcase
        end
        OMPF_AX_RESP:
        if (s_axi_rready)
          rdState_reg <= OMPF_AX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### bench/ompf_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ompf_top_sva
  import ompf_pkg::*;
#(
  parameter int AREAS = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] activeMode,
  input wire logic romEnabled,
  input wire logic flashProgAllowed,
  input wire logic flashBootMode,
  input wire logic flashUserMode,
  input wire logic busWide,
  input wire logic [7:0] portAAddrEn,
  input wire logic [7:0] portBAddrEn,
  input wire logic [7:0] portCAddrEn,
  input wire logic portDDataEn,
  input wire logic portEDataEn,
  input wire logic [7:0] portFCtrlEn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  boot_mode_a: assert property (
    flashBootMode |-> flashProgAllowed && activeMode inside {4'ha, 4'hb})
    else $error("boot flag outside boot modes");
  user_mode_a: assert property (
    flashUserMode |-> flashProgAllowed && activeMode inside {4'he, 4'hf})
    else $error("user flag outside user modes");
  flash_prog_a: assert property (
    flashProgAllowed == (activeMode[3] && activeMode[1]))
    else $error("flash programming flag wrong for mode");
  rom_off_a: assert property (
    activeMode inside {4'h4, 4'h5} |-> !romEnabled && portBAddrEn == 8'hff)
    else $error("rom or address role wrong in rom-off mode");
  rom_on_a: assert property (
    activeMode inside {4'h6, 4'h7, 4'ha, 4'hb, 4'he, 4'hf} |-> romEnabled)
    else $error("rom not enabled");
  single_chip_a: assert property (
    activeMode inside {4'h7, 4'hb, 4'hf} |-> !portDDataEn && !portEDataEn
    && {portAAddrEn, portBAddrEn, portCAddrEn, portFCtrlEn} == 32'h0)
    else $error("bus role seen in single chip mode");
  expanded_a: assert property (
    activeMode inside {4'h4, 4'h5, 4'h6, 4'ha, 4'he}
    |-> portDDataEn && portFCtrlEn[5:4] == 2'b11)
    else $error("data or control role missing");
  wide_data_a: assert property (
    portEDataEn == busWide)
    else $error("port e data role differs from bus width");
  mode_hold_a: assert property (
    $past(rst_b, 5) |-> $stable(activeMode))
    else $error("mode changed after capture");
  cover property (activeMode == 4'h4 && busWide);
  cover property (activeMode == 4'hf && flashUserMode);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind ompf_top ompf_top_sva #(.AREAS(AREAS)) chk_i (.*);
`default_nettype wire

// ### bench/ompf_strap_model.sv
`timescale 1ns/10ps
`default_nettype none
module ompf_strap_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] wantMode,
  output logic [2:0] modeSelectPins,
  output logic flashWriteEnablePin
);
  logic [3:0] strap;
  //////////////////////////////////////////////////////////////////////////
  // Unsupported requests fall back to single chip
  assign strap = (wantMode inside {4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb,
    4'he, 4'hf}) ? wantMode : 4'h7;
  // Straps move only while reset is held
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      {flashWriteEnablePin, modeSelectPins} <= strap;
  end
endmodule
`default_nettype wire

// ### bench/ompf_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ompf_top_tb
  import ompf_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [2:0] modeSelectPins;
  logic flashWriteEnablePin;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, monM;
  logic [3:0] s_axi_wstrb = 4'hf, activeMode, m, wantMode = 4'h7;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, romEnabled, flashProgAllowed, flashBootMode;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic flashUserMode, busWide, portDDataEn, portEDataEn, flashRegsMapped;
  logic [7:0] portAAddrEn, portBAddrEn, portCAddrEn, portFCtrlEn;
  logic xp, ab, wide;
  logic [33:0] monE;
  logic [33:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [1:0] bQ[$];
  logic [3:0] modes[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'he, 4'hf};
  int errCount = 0, testsRun = 0;
  always #10 clk = ~clk;
  ompf_top #(.AREAS(8)) dut (.*);
  ompf_strap_model strap (.clk(clk), .rst_b(rst_b), .wantMode(wantMode),
    .modeSelectPins(modeSelectPins),
    .flashWriteEnablePin(flashWriteEnablePin));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    testsRun++;
    if (seen !== want)
    begin
      errCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 200)
    begin
      errCount++;
      $display("mismatch at %0t: handshake timeout", $time);
      finalReport();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    bQ.push_back((a > OFS_DECODE) ? 2'h2 : 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      bound(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e,
    input logic [31:0] k);
    int n;
    n = 0;
    @(posedge clk);
    expQ.push_back(e);
    mskQ.push_back(k);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      bound(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic probe(input logic [23:0] a, input logic [2:0] t);
    wr(OFS_ADDR_PROBE, {8'h00, a});
    rd(OFS_DECODE, {31'h0, t}, 32'h7);
  endtask
  // Read results against the oldest note
  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready && expQ.size() > 0)
    begin
      monE = expQ.pop_front();
      monM = mskQ.pop_front();
      check({s_axi_rresp, s_axi_rdata & monM},
        {monE[33:32], monE[31:0] & monM});
    end
    if (s_axi_bvalid && s_axi_bready && bQ.size() > 0)
      check(s_axi_bresp, bQ.pop_front());
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h51eb));
    for (int i = 0; i < 8; i++)
    begin
      m = modes[i];
      @(posedge clk);
      wantMode <= m;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      xp = m inside {4'h4, 4'h5, 4'h6, 4'ha, 4'he};
      ab = m inside {4'h4, 4'h5};
      check(activeMode, m);
      check({romEnabled, flashProgAllowed, flashBootMode},
        {!ab, m[3] & m[1], m inside {4'ha, 4'hb}});
      check(flashUserMode, m inside {4'he, 4'hf});
      check({portDDataEn, portFCtrlEn[5:4]}, {3{xp}});
      check(busWide, m == 4'h4);
      check({portCAddrEn, portBAddrEn, portAAddrEn},
        ab ? 24'hffff1f : 24'h0);
      rd(OFS_MODE_STATUS, {27'h1, 4'h0, m[2:0]}, 32'hff);
      rd(OFS_SYSCTRL, {26'h0, SYSCTRL_RESET}, 32'hff);
      rd(OFS_SYSCTRL_TWO, {26'h0, SYSCTRL_TWO_RESET}, 32'hff);
      if (ab)
      begin
        r = $urandom_range(255, 1);
        for (int k = 0; k < 2; k++)
        begin
          wide = (m == 4'h5) ^ k[0];
          wr(OFS_AREA_WIDTH, wide ? r : 32'h0);
          repeat (2) @(posedge clk);
          check({busWide, portEDataEn}, {wide, wide});
        end
      end
      if (m == 4'h6)
      begin
        r = $urandom & 32'hffffff;
        wr(OFS_PORT_DIR, r);
        repeat (2) @(posedge clk);
        check({portCAddrEn, portBAddrEn, portAAddrEn}, r[23:0]);
        wr(OFS_SYSCTRL_TWO, 32'hff);
        rd(OFS_SYSCTRL_TWO, {26'h0, SYSCTRL_TWO_MASK}, 32'hff);
        check(flashRegsMapped, 1'b1);
        probe(FLASH_REG_LO, DEC_FLASH_REG);
        probe(FLASH_REG_HI, DEC_FLASH_REG);
        wr(OFS_BUS_CTRL_LOW, 32'h20);
        probe(EAE_AREA_LO, DEC_EXTERNAL);
        wr(OFS_BUS_CTRL_LOW, 32'h0);
        probe(EAE_AREA_LO, DEC_ROM);
        probe(RAM_LO, DEC_RAM);
        // RAM off routes RAM range external in expanded mode
        wr(OFS_SYSCTRL, 32'h0);
        probe(RAM_LO, DEC_EXTERNAL);
        probe(RSVD_B_LO, DEC_RESERVED);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, {2'b10, 32'h0}, 32'hffffffff);
      end
      $display("mode %0d test done", m);
    end
    repeat (4) @(posedge clk);
    finalReport();
  end
endmodule
`default_nettype wire
